// ---- rtl/station_cfg_map.svh ----
`ifndef STATION_CFG_MAP_SVH
`define STATION_CFG_MAP_SVH

// ----------------------------------------
// Register byte offsets
// ----------------------------------------
`define CFG_OFS_DECODED 12'h000
`define CFG_OFS_SWITCH 12'h004
`define CFG_OFS_EVENT 12'h008

// ----------------------------------------
// Configuration DIP switch positions
// ----------------------------------------
`define DIP_RATE_BIT 0
`define DIP_FRAME_BIT 1
`define DIP_BANK_BIT 2
`define DIP_RSVD_BIT 3

// ----------------------------------------
// Decode constants
// ----------------------------------------
`define ADDR_BASE_LOW 8'h40
`define ADDR_BASE_HIGH 8'h50
`define FRAME_SHORT 6'h11
`define FRAME_LONG 6'h20
`define ROTARY_DISABLED 4'h0

// ----------------------------------------
// Output and held-switch values while reset is held (shipped defaults)
// ----------------------------------------
`define RST_RATE_HIGH 1'b1
`define RST_FRAME_LEN 6'h20
`define RST_STATION_ADDR 8'h41
`define RST_ADDR_VALID 1'b1
`define RST_DIP 4'h3
`define RST_ROTARY 4'h1

// ----------------------------------------
// Field positions in the decoded register
// ----------------------------------------
`define FLD_RATE 0
`define FLD_FRAME_LSB 8
`define FLD_ADDR_LSB 16
`define FLD_VALID 24

// ----------------------------------------
// Field positions in the event register
// ----------------------------------------
`define FLD_CHANGED 0
`define FLD_RSVD_ON 1
`define FLD_HELD 2

`endif

// ---- rtl/station_cfg_pkg.sv ----
package station_cfg_pkg;

  // Capture sequencer states
  typedef enum logic [0:0]
  {
    ST_SAMPLE = 1'b0,
    ST_HELD = 1'b1
  } capture_e;

  // Complete state of the top module
  typedef struct packed
  {
    capture_e phase;
    logic rate_10m;
    logic [5:0] frame_len;
    logic [7:0] station_address;
    logic address_valid;
    logic [3:0] dip_held;
    logic [3:0] rot_held;
    logic changed;
    logic hreadyout;
    logic hresp;
    logic [31:0] hrdata;
    logic wr_pend;
    logic [11:0] wr_ofs;
  } cfg_state_s;

endpackage

// ---- rtl/switch_decode.sv ----
`timescale 1ns/1ps
`include "station_cfg_map.svh"

module switch_decode
(
  input wire logic [3:0] dip,
  input wire logic [3:0] rotary,
  output logic rate_10m,
  output logic [5:0] frame_len,
  output logic [7:0] station_address,
  output logic address_valid
);

  // ----------------------------------------
  // Pure decode of one switch setting
  // ----------------------------------------

  // Bit rate, frame length, address and validity
  always_comb
  begin
    rate_10m = dip[`DIP_RATE_BIT];
    if (dip[`DIP_RATE_BIT] && dip[`DIP_FRAME_BIT])
    begin
      frame_len = `FRAME_LONG;
    end
    else
    begin
      frame_len = `FRAME_SHORT;
    end
    if (dip[`DIP_BANK_BIT])
    begin
      station_address = `ADDR_BASE_HIGH + {4'h0, rotary};
    end
    else
    begin
      station_address = `ADDR_BASE_LOW + {4'h0, rotary};
    end
    address_valid = dip[`DIP_BANK_BIT] || (rotary != `ROTARY_DISABLED);
  end

endmodule

// ---- rtl/fieldbus_station_config.sv ----
// Added by the designer: the register addresses and the AHB-Lite slave port.
`timescale 1ns/1ps
`include "station_cfg_map.svh"

// Notes on behaviour
// - Configuration position one OFF selects the 4 Mbps link rate and ON selects 10 Mbps.
// - Configuration position two OFF selects a 17-byte frame and ON selects a 32-byte frame.
// - At the 4 Mbps rate the frame-length position is ignored and the frame is always 17 bytes.
// - The station address is the rotary value added to 40H with position three OFF, or to 50H with it ON.
// - With position three OFF and the rotary at 0 the address is reported as disabled.
// - Shipped setting is rotary 1, position three OFF, rate ON, frame ON, giving address 41H.
// - Switch changes take effect only after the next power-on reset.
module fieldbus_station_config
(
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  input wire logic [3:0] address_rotary_switch,
  input wire logic [3:0] link_config_dip_switch,
  output logic rate_10m,
  output logic [5:0] frame_len,
  output logic [7:0] station_address,
  output logic address_valid
);

  import station_cfg_pkg::*;

  // ----------------------------------------
  // State and decoder
  // ----------------------------------------

  cfg_state_s state;
  cfg_state_s next_state;
  logic dec_rate;
  logic [5:0] dec_frame;
  logic [7:0] dec_addr;
  logic dec_valid;
  logic addr_phase;
  logic live_differs;
  logic [3:0] dip_diff;
  logic [3:0] rot_diff;

  // Decode of the live switch setting
  switch_decode u_decode
  (
    .dip(link_config_dip_switch),
    .rotary(address_rotary_switch),
    .rate_10m(dec_rate),
    .frame_len(dec_frame),
    .station_address(dec_addr),
    .address_valid(dec_valid)
  );

  // ----------------------------------------
  // Power-up capture
  // ----------------------------------------

  // Takes the decoded setting and the raw switches behind it
  function automatic cfg_state_s capture_setting
  (
    input cfg_state_s s,
    input logic rate,
    input logic [5:0] frame,
    input logic [7:0] addr,
    input logic valid,
    input logic [3:0] dip_live,
    input logic [3:0] rot_live
  );
    cfg_state_s n;
    n = s;
    n.rate_10m = rate;
    n.frame_len = frame;
    n.station_address = addr;
    n.address_valid = valid;
    n.dip_held = dip_live;
    n.rot_held = rot_live;
    n.phase = ST_HELD;
    return n;
  endfunction

  // ----------------------------------------
  // Register read mux
  // ----------------------------------------

  // Decoded configuration as software sees it
  function automatic logic [31:0] decoded_word
  (
    input cfg_state_s s
  );
    logic [31:0] word;
    word = 32'h0000_0000;
    word[`FLD_RATE] = s.rate_10m;
    word[`FLD_FRAME_LSB +: 6] = s.frame_len;
    word[`FLD_ADDR_LSB +: 8] = s.station_address;
    word[`FLD_VALID] = s.address_valid;
    return word;
  endfunction

  // Live and held switch settings side by side
  function automatic logic [31:0] switch_word
  (
    input cfg_state_s s,
    input logic [3:0] dip_live,
    input logic [3:0] rot_live
  );
    logic [31:0] word;
    word = 32'h0000_0000;
    word[3:0] = dip_live;
    word[7:4] = rot_live;
    word[11:8] = s.dip_held;
    word[15:12] = s.rot_held;
    return word;
  endfunction

  // Change flag, reserved contact and capture status
  function automatic logic [31:0] event_word
  (
    input cfg_state_s s
  );
    logic [31:0] word;
    word = 32'h0000_0000;
    word[`FLD_CHANGED] = s.changed;
    word[`FLD_RSVD_ON] = s.dip_held[`DIP_RSVD_BIT];
    word[`FLD_HELD] = (s.phase == ST_HELD);
    return word;
  endfunction

  // Word seen by software at a byte offset; unmapped reads zero
  function automatic logic [31:0] reg_read
  (
    input logic [11:0] ofs,
    input cfg_state_s s,
    input logic [3:0] dip_live,
    input logic [3:0] rot_live
  );
    logic [31:0] word;
    word = 32'h0000_0000;
    case (ofs)
      `CFG_OFS_DECODED:
      begin
        word = decoded_word(s);
      end
      `CFG_OFS_SWITCH:
      begin
        word = switch_word(s, dip_live, rot_live);
      end
      `CFG_OFS_EVENT:
      begin
        word = event_word(s);
      end
      default:
      begin
        word = 32'h0000_0000;
      end
    endcase
    return word;
  endfunction

  // ----------------------------------------
  // Bus write decode
  // ----------------------------------------

  // Write of a one to the change flag asks to clear it
  function automatic logic clear_request
  (
    input logic pend,
    input logic [11:0] ofs,
    input logic [31:0] wdata
  );
    return pend && (ofs == `CFG_OFS_EVENT) && wdata[`FLD_CHANGED];
  endfunction

  // Valid address phase addressed to this slave
  assign addr_phase = hsel && hready && htrans[1];

  // ----------------------------------------
  // Switch change watch
  // ----------------------------------------

  // One compare per DIP contact, live against held
  for (genvar b = 0; b < 4; b++)
  begin : g_dip_cmp
    assign dip_diff[b] = link_config_dip_switch[b] ^ state.dip_held[b];
  end

  // One compare per rotary code bit, live against held
  for (genvar b = 0; b < 4; b++)
  begin : g_rot_cmp
    assign rot_diff[b] = address_rotary_switch[b] ^ state.rot_held[b];
  end

  // Any difference means the switches moved since power-up
  assign live_differs = (|dip_diff) || (|rot_diff);

  // ----------------------------------------
  // Next-state logic
  // ----------------------------------------

  // Capture once after reset, then serve the bus
  always_comb
  begin
    next_state = state;
    next_state.hreadyout = 1'b1;
    next_state.hresp = 1'b0;
    case (state.phase)
      ST_SAMPLE:
      begin
        // First edge after release takes the switches once
        next_state = capture_setting(next_state, dec_rate, dec_frame, dec_addr, dec_valid,
          link_config_dip_switch, address_rotary_switch);
      end
      ST_HELD:
      begin
        // Outputs frozen until the next reset
        next_state.phase = ST_HELD;
        // Running change only raises a sticky flag
        if (live_differs)
        begin
          next_state.changed = 1'b1;
        end
        else if (clear_request(state.wr_pend, state.wr_ofs, hwdata))
        begin
          next_state.changed = 1'b0;
        end
      end
      default:
      begin
        next_state.phase = ST_SAMPLE;
      end
    endcase
    // Address phase: load read data and note a pending write
    if (addr_phase)
    begin
      if (hwrite)
      begin
        next_state.hrdata = 32'h0000_0000;
      end
      else
      begin
        next_state.hrdata = reg_read(haddr[11:0], state, link_config_dip_switch, address_rotary_switch);
      end
      next_state.wr_pend = hwrite;
      next_state.wr_ofs = haddr[11:0];
    end
    else
    begin
      next_state.wr_pend = 1'b0;
    end
  end

  // ----------------------------------------
  // State register
  // ----------------------------------------

  // Reset shows the shipped-default decode
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      state.phase <= ST_SAMPLE;
      state.rate_10m <= `RST_RATE_HIGH;
      state.frame_len <= `RST_FRAME_LEN;
      state.station_address <= `RST_STATION_ADDR;
      state.address_valid <= `RST_ADDR_VALID;
      state.dip_held <= `RST_DIP;
      state.rot_held <= `RST_ROTARY;
      state.changed <= 1'b0;
      state.hreadyout <= 1'b1;
      state.hresp <= 1'b0;
      state.hrdata <= 32'h0000_0000;
      state.wr_pend <= 1'b0;
      state.wr_ofs <= 12'h000;
    end
    else
    begin
      state <= next_state;
    end
  end

  // ----------------------------------------
  // Outputs straight from flops
  // ----------------------------------------

  // Bus answer
  assign hreadyout = state.hreadyout;
  assign hresp = state.hresp;
  assign hrdata = state.hrdata;

  // Decoded configuration
  assign rate_10m = state.rate_10m;
  assign frame_len = state.frame_len;
  assign station_address = state.station_address;
  assign address_valid = state.address_valid;

endmodule

// ---- sim/station_cfg_checker.sv ----
`timescale 1ns/1ps
module station_cfg_checker
(
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic [3:0] link_config_dip_switch,
  input wire logic [3:0] address_rotary_switch,
  input wire logic rate_10m,
  input wire logic [5:0] frame_len,
  input wire logic [7:0] station_address,
  input wire logic address_valid
);
  wire logic [3:0] dip = link_config_dip_switch;
  wire logic [3:0] rot = address_rotary_switch;
  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);
  // ----------------------------------------
  // Capture steps
  // ----------------------------------------
  sequence s_release;
    $rose(hresetn);
  endsequence
  sequence s_running;
    hresetn && $past(hresetn) && $past(hresetn, 2);
  endsequence
  // ----------------------------------------
  // Decode and hold checks
  // ----------------------------------------
  a_rate_decode: assert property (s_release |=> rate_10m == $past(dip[0]))
    else $error("rate wrong");
  a_frame_decode: assert property (s_release |=> frame_len == (($past(dip[0]) && $past(dip[1])) ? 6'h20 : 6'h11))
    else $error("frame wrong");
  a_slow_frame: assert property (!rate_10m |-> frame_len == 6'h11)
    else $error("slow frame wrong");
  a_addr_decode: assert property (s_release |=> station_address == ($past(dip[2]) ? 8'h50 : 8'h40) + {4'h0, $past(rot)})
    else $error("address wrong");
  a_addr_valid: assert property (s_release |=> address_valid == ($past(dip[2]) || $past(rot) != 4'h0))
    else $error("valid wrong");
  a_valid_pair: assert property (address_valid == (station_address != 8'h40))
    else $error("valid and address disagree");
  a_cfg_held: assert property (s_running |-> $stable({rate_10m, frame_len}))
    else $error("link setting moved");
  a_addr_held: assert property (s_running |-> $stable({station_address, address_valid}))
    else $error("address moved");
endmodule

// ---- sim/switch_panel.sv ----
`timescale 1ns/1ps
// Installer switches; reserved position always left OFF
module switch_panel
(
  input wire logic [2:0] want_dip,
  input wire logic [3:0] want_rot,
  output logic [3:0] dip,
  output logic [3:0] rotary
);
  assign dip = {1'b0, want_dip};
  assign rotary = want_rot;
endmodule

// ---- sim/fieldbus_station_config_tb.sv ----
`timescale 1ns/1ps
`include "station_cfg_map.svh"
module fieldbus_station_config_tb;
  logic hclk = 1'b0;
  logic hresetn = 1'b0;
  logic hsel = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic [2:0] hsize = 3'h2;
  logic [31:0] hwdata = 32'h0;
  logic [2:0] want_dip = 3'h3;
  logic [3:0] want_rot = 4'h1;
  logic hreadyout, hresp, rate_10m, address_valid;
  logic [31:0] hrdata, rd;
  logic [3:0] dip, rot;
  logic [5:0] frame_len;
  logic [7:0] station_address;
  int n_errors = 0;
  int checks = 0;
  int cycles = 0;
  wire logic [15:0] outs = {rate_10m, frame_len, station_address, address_valid};
  // ----------------------------------------
  // Clock, switches and design
  // ----------------------------------------
  always #4 hclk = ~hclk;
  switch_panel sw (.want_dip(want_dip), .want_rot(want_rot), .dip(dip), .rotary(rot));
  fieldbus_station_config DUT (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp),
    .hrdata(hrdata), .address_rotary_switch(rot), .link_config_dip_switch(dip), .rate_10m(rate_10m),
    .frame_len(frame_len), .station_address(station_address), .address_valid(address_valid));
  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  function logic [15:0] dec(input logic [2:0] d, input logic [3:0] r);
    return {d[0], (d[0] & d[1]) ? 6'h20 : 6'h11, (d[2] ? 8'h50 : 8'h40) + {4'h0, r}, d[2] | (r != 4'h0)};
  endfunction
  task chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    checks++;
    if (got !== exp)
    begin
      n_errors++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask
  // Single word transfer, waits on hready in both phases
  task bus(input logic w, input logic [31:0] a, input logic [31:0] wd);
    hsel <= 1'b1;
    haddr <= a;
    htrans <= 2'h2;
    hwrite <= w;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wd;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    rd = hrdata;
    chk("hresp", 32'h0, {31'h0, hresp});
  endtask
  // Power cycle with given switches, then check the decode
  task cap(input logic [2:0] d, input logic [3:0] r);
    want_dip <= d;
    want_rot <= r;
    hresetn <= 1'b0;
    repeat (6) @(posedge hclk);
    chk("reset outs", 32'h0000C083, {16'h0, outs});
    hresetn <= 1'b1;
    repeat (2) @(posedge hclk);
    chk("decode", {16'h0, dec(d, r)}, {16'h0, outs});
  endtask
  task results;
    $display("checks %0d errors %0d", checks, n_errors);
    if (n_errors == 0 && checks > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  // Hang guard
  always @(posedge hclk)
  begin
    cycles <= cycles + 1;
    if (cycles == 4000)
    begin
      n_errors++;
      results();
    end
  end
  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial
  begin
    cap(3'h3, 4'h1);
    for (int i = 0; i < 24; i++)
      cap(i[2:0], (i >= 16) ? 4'hF : {3'h0, i[3]});
    bus(1'b0, `CFG_OFS_DECODED, 32'h0);
    chk("decoded reg", 32'h015F2001, rd);
    want_dip <= 3'h0;
    want_rot <= 4'h0;
    repeat (3) @(posedge hclk);
    chk("held outs", {16'h0, dec(3'h7, 4'hF)}, {16'h0, outs});
    bus(1'b0, `CFG_OFS_EVENT, 32'h0);
    chk("event set", 32'h5, rd);
    bus(1'b0, `CFG_OFS_SWITCH, 32'h0);
    chk("switch reg", 32'h0000F700, rd);
    bus(1'b1, `CFG_OFS_EVENT, 32'h1);
    bus(1'b0, `CFG_OFS_EVENT, 32'h0);
    chk("set over clear", 32'h5, rd);
    want_dip <= 3'h7;
    want_rot <= 4'hF;
    repeat (2) @(posedge hclk);
    bus(1'b1, `CFG_OFS_EVENT, 32'h1);
    bus(1'b1, `CFG_OFS_DECODED, 32'h0);
    bus(1'b0, `CFG_OFS_EVENT, 32'h0);
    chk("event clear", 32'h1 << `FLD_HELD, rd);
    bus(1'b0, `CFG_OFS_DECODED, 32'h0);
    chk("read only", 32'h015F2001, rd);
    bus(1'b0, 32'h0000000C, 32'h0);
    chk("unmapped", 32'h0, rd);
    results();
  end
endmodule
bind fieldbus_station_config station_cfg_checker chk_i (.hclk(hclk), .hresetn(hresetn),
  .link_config_dip_switch(link_config_dip_switch), .address_rotary_switch(address_rotary_switch),
  .rate_10m(rate_10m), .frame_len(frame_len), .station_address(station_address), .address_valid(address_valid));
